// File: rtl/cpbi_pkg.sv
/*
Shared constants and carrier types for the prefetch and bus interface block.
Assumes one clock at 200 MHz and a synchronous active-high reset.
*/
package cpbi_pkg;
	localparam int CPBI_ADDR_W = 20;
	localparam int CPBI_SEG_SHIFT = 4;
	localparam int CPBI_WIDE_QDEPTH = 6;
	localparam int CPBI_NARROW_QDEPTH = 4;
	localparam int CPBI_WIDE_FREE_MIN = 2;
	localparam int CPBI_NARROW_FREE_MIN = 1;
	localparam logic [19:0] CPBI_RESET_CS = 20'hFFFF0;
	localparam logic [15:0] CPBI_RESET_IP = 16'h0000;
	localparam int CPBI_SKID_DEPTH = 2;

	typedef enum logic [2:0] {
		CPBI_QUIET,
		CPBI_T1,
		CPBI_T2,
		CPBI_T3,
		CPBI_STALL,
		CPBI_T4
	} cpbi_state_e;

	typedef struct packed {
		logic [15:0] seg;
		logic [15:0] off;
		logic [15:0] wdata;
		logic write;
		logic io;
		logic wordOp;
	} cpbi_req_s;

	typedef struct packed {
		logic [19:0] addr;
		logic [15:0] wdata;
		logic write;
		logic io;
		logic byteHighEn;
	} cpbi_cyc_s;
endpackage

// File: rtl/cpbi_skid.sv
/*
Two-entry buffer with valid and ready on both sides.
Assumes both sides run on the same clock.
*/
`timescale 1ns/1ps
module cpbi_skid import cpbi_pkg::*; #(
	parameter int WIDTH = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	logic [WIDTH-1:0] store [CPBI_SKID_DEPTH];
	logic rdPtr;
	logic wrPtr;
	logic [1:0] count;

	assign inReady = count != 2'(CPBI_SKID_DEPTH);
	assign outValid = count != 2'h0;
	assign outData = store[rdPtr];

	always_ff @(posedge clk) begin
		if (rst) begin
			rdPtr <= 1'b0;
			wrPtr <= 1'b0;
			count <= 2'h0;
		end else begin
			if (inValid && inReady) begin
				store[wrPtr] <= inData;
				wrPtr <= ~wrPtr;
			end
			if (outValid && outReady) begin
				rdPtr <= ~rdPtr;
			end
			count <= count + 2'(inValid && inReady) - 2'(outValid && outReady);
		end
	end

	fullNever_a: assert property (@(posedge clk) disable iff (rst) count <= 2'h2)
		else $error("Buffer count exceeds two.");
endmodule

// File: rtl/cpbi_core.sv
/*
Bus side unit: prefetch queue, address adder and bus cycle sequencer.
Assumes external pins are synchronised here, an external driver resolves the
data pins from the enable, and the execute side keeps requests stable.
*/
// Operation
// - Drive 20-bit physical address on bus.
// - Wide uses 16-bit data, narrow 8-bit.
// - Strap selects small-system or multiprocessor control.
// - Queue depth six wide, four narrow.
// - Execute side stalls on empty queue.
// - Execute side requests data cycles from here.
// - Wide fetch needs two free, no request.
// - Narrow fetch starts with one free byte.
// - Fetch loads two bytes wide (one from an odd offset), one narrow.
// - Running fetch finishes before requested cycle.
// - Segment and offset summed in own adder.
// - All bus cycles and operand transfers here.
// - Address T1, write T2-T4, read T3; code samples read data no earlier than the second wait state after T3.
// - Jump flushes queue, restarts at target.
// - No pending work gives quiet states.
`timescale 1ns/1ps
module cpbi_core import cpbi_pkg::*; #(
	parameter bit WIDE = 1'b1,
	parameter int QDEPTH = WIDE ? CPBI_WIDE_QDEPTH : CPBI_NARROW_QDEPTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic systemConfigStrap,
	output logic [7:0] codeByte,
	output logic codeValid,
	input wire logic codeTake,
	input wire logic jumpValid,
	input wire logic [15:0] jumpSeg,
	input wire logic [15:0] jumpOff,
	input wire logic reqValid,
	output logic reqReady,
	input wire cpbi_req_s req,
	output logic rspValid,
	input wire logic rspReady,
	output logic [15:0] rspData,
	output logic [19:0] busAddr,
	output logic addrLatch,
	output logic [15:0] dataOut,
	output logic [15:0] dataOe_n,
	input wire logic [15:0] dataIn,
	input wire logic readyPin,
	output logic readStrobe_n,
	output logic writeStrobe_n,
	output logic ioSelect,
	output logic byteHigh_n,
	output logic [2:0] cycleStatus_n,
	output logic smallSystemMode,
	output logic [1:0] queueStatus
);
	localparam int FREE_MIN = WIDE ? CPBI_WIDE_FREE_MIN : CPBI_NARROW_FREE_MIN;
	localparam int CW = $clog2(QDEPTH + 1);
	localparam int QW = $clog2(QDEPTH);
	// Cycles spent in T3 or wait states before the synchronised ready and data reflect this cycle.
	localparam int SYNC_WAIT = 2;

	cpbi_state_e state;
	logic [7:0] queue [QDEPTH];
	logic [CW-1:0] qCount;
	logic [$clog2(QDEPTH)-1:0] qHead;
	logic [15:0] codeSeg;
	logic [15:0] fetchOff;
	logic curFetch;
	cpbi_cyc_s cyc;
	logic [15:0] readLatch;
	logic strapMeta, strapSync, readyMeta, readySync;
	logic [15:0] dinMeta, dinSync;
	logic needFetch, startReq, startFetch, skidReady, skidValid;
	logic [15:0] skidData;
	logic [CW-1:0] qFree;
	logic [CW-1:0] loadCount;
	logic popByte;
	logic [19:0] reqAddr, fetchAddr;
	logic [1:0] waitCnt;
	logic sampleNow;
	logic staleFetch;
	logic [QW-1:0] slot0, slot1;

	always_ff @(posedge clk) begin
		strapMeta <= systemConfigStrap;
		strapSync <= strapMeta;
		readyMeta <= readyPin;
		readySync <= readyMeta;
		dinMeta <= dataIn;
		dinSync <= dinMeta;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			smallSystemMode <= strapSync;
		end
	end

	assign reqAddr = 20'({req.seg, 4'h0} + {4'h0, req.off});
	assign fetchAddr = 20'({codeSeg, 4'h0} + {4'h0, fetchOff});

	assign qFree = CW'(QDEPTH) - qCount;
	assign popByte = codeValid && codeTake;
	assign needFetch = qFree >= CW'(FREE_MIN) && !jumpValid;
	assign startReq = state == CPBI_QUIET && reqValid && skidReady && !jumpValid;
	assign startFetch = state == CPBI_QUIET && !startReq && needFetch
		&& !(WIDE && reqValid);
	assign reqReady = startReq;

	assign codeValid = qCount != '0 && !jumpValid;
	assign codeByte = queue[qHead];
	assign queueStatus = {jumpValid, popByte};

	assign loadCount = (state == CPBI_T4 && curFetch && !staleFetch) ?
		((WIDE && !fetchOff[0]) ? CW'(2) : CW'(1)) : '0;

	// Ready and data pass two flops, so the cycle may end only once they are current.
	always_ff @(posedge clk) begin
		if (rst) begin
			waitCnt <= 2'h0;
		end else if (state == CPBI_T3 || state == CPBI_STALL) begin
			if (waitCnt != 2'h3) begin
				waitCnt <= waitCnt + 2'h1;
			end
		end else begin
			waitCnt <= 2'h0;
		end
	end
	assign sampleNow = (state == CPBI_T3 || state == CPBI_STALL) && readySync
		&& waitCnt >= 2'(SYNC_WAIT);

	// Fetch in flight at a jump is dropped.
	always_ff @(posedge clk) begin
		if (rst) begin
			staleFetch <= 1'b0;
		end else if (jumpValid && curFetch && state != CPBI_QUIET && state != CPBI_T4) begin
			staleFetch <= 1'b1;
		end else if (state == CPBI_T4) begin
			staleFetch <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= CPBI_QUIET;
		end else begin
			case (state)
				CPBI_QUIET: begin
					if (startReq || startFetch) begin
						state <= CPBI_T1;
					end
				end
				CPBI_T1: state <= CPBI_T2;
				CPBI_T2: state <= CPBI_T3;
				CPBI_T3: state <= sampleNow ? CPBI_T4 : CPBI_STALL;
				CPBI_STALL: state <= sampleNow ? CPBI_T4 : CPBI_STALL;
				CPBI_T4: state <= CPBI_QUIET;
				default: state <= CPBI_QUIET;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cyc <= '0;
			curFetch <= 1'b0;
		end else if (startReq) begin
			cyc.addr <= reqAddr;
			cyc.wdata <= (WIDE && reqAddr[0]) ? {req.wdata[7:0], 8'h00} : req.wdata;
			cyc.write <= req.write;
			cyc.io <= req.io;
			cyc.byteHighEn <= WIDE && (req.wordOp || reqAddr[0]);
			curFetch <= 1'b0;
		end else if (startFetch) begin
			cyc.addr <= fetchAddr;
			cyc.wdata <= '0;
			cyc.write <= 1'b0;
			cyc.io <= 1'b0;
			cyc.byteHighEn <= WIDE;
			curFetch <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			readLatch <= '0;
		end else if (sampleNow) begin
			readLatch <= dinSync;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			codeSeg <= CPBI_RESET_CS[19:4];
			fetchOff <= CPBI_RESET_IP;
		end else if (jumpValid) begin
			codeSeg <= jumpSeg;
			fetchOff <= jumpOff;
		end else if (state == CPBI_T4 && curFetch) begin
			fetchOff <= fetchOff + 16'(loadCount);
		end
	end

	always_ff @(posedge clk) begin
		if (rst || jumpValid) begin
			qCount <= '0;
			qHead <= '0;
		end else begin
			qCount <= qCount + loadCount - CW'(popByte);
			if (popByte) begin
				qHead <= (32'(qHead) == QDEPTH - 1) ? '0 : qHead + 1'b1;
			end
		end
	end

	assign slot0 = QW'((32'(qHead) + 32'(qCount)) % QDEPTH);
	assign slot1 = QW'((32'(qHead) + 32'(qCount) + 1) % QDEPTH);
	for (genvar j = 0; j < QDEPTH; j++) begin : gEntry
		always_ff @(posedge clk) begin
			if (!jumpValid && loadCount != '0 && slot0 == QW'(j)) begin
				queue[j] <= (WIDE && fetchOff[0]) ? readLatch[15:8] : readLatch[7:0];
			end else if (!jumpValid && loadCount == CW'(2) && slot1 == QW'(j)) begin
				queue[j] <= readLatch[15:8];
			end
		end
	end

	assign skidValid = state == CPBI_T4 && !curFetch && !cyc.write;
	assign skidData = (WIDE && cyc.addr[0]) ? {8'h00, readLatch[15:8]} : readLatch;

	cpbi_skid #(.WIDTH(16)) uRsp (
		.clk(clk),
		.rst(rst),
		.inValid(skidValid),
		.inReady(skidReady),
		.inData(skidData),
		.outValid(rspValid),
		.outReady(rspReady),
		.outData(rspData)
	);

	always_ff @(posedge clk) begin
		if (rst) begin
			busAddr <= '0;
			addrLatch <= 1'b0;
			dataOut <= '0;
			dataOe_n <= '1;
			readStrobe_n <= 1'b1;
			writeStrobe_n <= 1'b1;
			ioSelect <= 1'b0;
			byteHigh_n <= 1'b1;
			cycleStatus_n <= 3'h7;
		end else begin
			addrLatch <= state == CPBI_QUIET && (startReq || startFetch);
			busAddr <= (startReq ? reqAddr : fetchAddr);
			if (state == CPBI_T1 || state == CPBI_T2 || state == CPBI_T3 || state == CPBI_STALL) begin
				busAddr <= cyc.addr;
			end
			dataOut <= cyc.write ? cyc.wdata : 16'(cyc.addr);
			dataOe_n <= (state == CPBI_QUIET && (startReq || startFetch)) ||
				(cyc.write && state inside {CPBI_T1, CPBI_T2, CPBI_T3, CPBI_STALL})
				? (WIDE ? 16'h0000 : 16'hFF00) : 16'hFFFF;
			readStrobe_n <= !(state inside {CPBI_T1, CPBI_T2, CPBI_T3, CPBI_STALL} && !cyc.write
				&& smallSystemMode && !sampleNow);
			writeStrobe_n <= !(state inside {CPBI_T1, CPBI_T2, CPBI_T3, CPBI_STALL} && cyc.write
				&& smallSystemMode && !sampleNow);
			ioSelect <= cyc.io;
			byteHigh_n <= !cyc.byteHighEn;
			cycleStatus_n <= (!smallSystemMode && state == CPBI_QUIET && (startReq || startFetch))
				? {!startReq || !req.io, !(startReq && req.write), 1'b0} : 3'h7;
		end
	end

	sequence waitRun_s;
		state == CPBI_STALL && !readySync;
	endsequence
	sequence cycStart_s;
		state == CPBI_QUIET && (startReq || startFetch);
	endsequence

	minFour_a: assert property (@(posedge clk) disable iff (rst)
		cycStart_s |=> state == CPBI_T1 ##1 state == CPBI_T2 ##1 state == CPBI_T3)
		else $error("Bus cycle shorter than four states.");
	waitHold_a: assert property (@(posedge clk) disable iff (rst)
		waitRun_s |=> state == CPBI_STALL && $stable(cyc))
		else $error("Wait state left early or data changed.");
	queueBound_a: assert property (@(posedge clk) disable iff (rst)
		qCount <= CW'(QDEPTH))
		else $error("Queue overflow.");
	fetchRoom_a: assert property (@(posedge clk) disable iff (rst)
		startFetch |-> qFree >= CW'(FREE_MIN) && !(WIDE && reqValid))
		else $error("Fetch started without room.");
	fetchFinish_a: assert property (@(posedge clk) disable iff (rst)
		(state == CPBI_T2 && curFetch) |=> curFetch throughout (state != CPBI_QUIET)[*2])
		else $error("Fetch cycle preempted.");
	flushQueue_a: assert property (@(posedge clk) disable iff (rst)
		jumpValid |=> qCount == '0)
		else $error("Queue not flushed on jump.");
	emptyStall_a: assert property (@(posedge clk) disable iff (rst)
		qCount == '0 |-> !codeValid)
		else $error("Code offered from empty queue.");
	quietIdle_a: assert property (@(posedge clk) disable iff (rst)
		(state == CPBI_QUIET && !reqValid && !needFetch) |=> state == CPBI_QUIET)
		else $error("Bus cycle started with no work.");
	loadBytes_a: assert property (@(posedge clk) disable iff (rst)
		(state == CPBI_T4 && curFetch && !jumpValid && !popByte)
		|=> qCount == $past(qCount) + $past(loadCount))
		else $error("Wrong byte count loaded.");
endmodule

// File: testbench/cpbi_mem_model.sv
/*
Memory model on the far side of the multiplexed bus.
Assumes the core latches the address with addrLatch and reads with readStrobe_n low.
*/
`timescale 1ns/1ps
module cpbi_mem_model (
	input wire logic clk,
	input wire logic [19:0] busAddr,
	input wire logic addrLatch,
	input wire logic readStrobe_n,
	input wire logic writeStrobe_n,
	input wire logic [15:0] dataOut,
	input wire logic [7:0] waits,
	output logic [15:0] dataIn,
	output logic readyPin,
	output logic [19:0] lastWrAddr,
	output logic [15:0] lastWrData
);
	logic [19:0] addr = 20'h00000;
	logic [7:0] cnt = 8'h00;
	logic [15:0] prev = 16'h0000;
	function automatic logic [7:0] mem(input logic [19:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h3C;
	endfunction
	always @(posedge clk) begin
		if (addrLatch) begin
			addr <= busAddr;
			cnt <= waits;
		end else if (cnt != 8'h00) begin
			cnt <= cnt - 8'h01;
		end
		if (!writeStrobe_n) begin
			lastWrAddr <= addr;
			lastWrData <= dataOut;
		end
		prev <= dataIn;
	end
	assign readyPin = (cnt == 8'h00);
	assign dataIn = !readStrobe_n ? {mem({addr[19:1], 1'b1}), mem({addr[19:1], 1'b0})} : ~prev;
endmodule

// File: testbench/cpu_prefetch_bus_interface_tb.sv
/*
Self-checking bench for the prefetch and bus core, wide variant.
Assumes the memory model answers every cycle and read data is always taken.
*/
`timescale 1ns/1ps
module cpu_prefetch_bus_interface_tb;
	import cpbi_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic codeTake = 1'b0;
	logic jumpValid = 1'b0;
	logic [15:0] jumpSeg = 16'h0000;
	logic [15:0] jumpOff = 16'h0000;
	logic reqValid = 1'b0;
	cpbi_req_s req = '0;
	logic [7:0] waits = 8'h00;
	logic [7:0] codeByte;
	logic codeValid, reqReady, rspValid, addrLatch, readyPin, readStrobe_n, writeStrobe_n;
	logic smallMode;
	logic [15:0] rspData, dataOut, dataOe_n, dataIn, lastWrData;
	logic [19:0] busAddr, lastWrAddr;
	int num_errors = 0;
	int checks_done = 0;
	int latchCount = 0;

	cpbi_core #(.WIDE(1'b1)) u_dut (.clk(clk), .rst(rst), .systemConfigStrap(1'b1),
		.codeByte(codeByte), .codeValid(codeValid), .codeTake(codeTake),
		.jumpValid(jumpValid), .jumpSeg(jumpSeg), .jumpOff(jumpOff),
		.reqValid(reqValid), .reqReady(reqReady), .req(req), .rspValid(rspValid),
		.rspReady(1'b1), .rspData(rspData), .busAddr(busAddr), .addrLatch(addrLatch),
		.dataOut(dataOut), .dataOe_n(dataOe_n), .dataIn(dataIn), .readyPin(readyPin),
		.readStrobe_n(readStrobe_n), .writeStrobe_n(writeStrobe_n), .ioSelect(),
		.byteHigh_n(), .cycleStatus_n(), .smallSystemMode(smallMode), .queueStatus());
	cpbi_mem_model u_mem (.clk(clk), .busAddr(busAddr), .addrLatch(addrLatch),
		.readStrobe_n(readStrobe_n), .writeStrobe_n(writeStrobe_n), .dataOut(dataOut),
		.waits(waits), .dataIn(dataIn), .readyPin(readyPin), .lastWrAddr(lastWrAddr),
		.lastWrData(lastWrData));

	initial begin
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (addrLatch === 1'b1) latchCount++;
	end
	function automatic logic [7:0] mem(input logic [19:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h3C;
	endfunction
	task automatic check(input logic [19:0] seen, input logic [19:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic pop_bytes(input logic [19:0] base, input int n);
		int k;
		for (int i = 0; i < n; i++) begin
			k = 0;
			@(negedge clk);
			while (codeValid !== 1'b1 && k < 200) begin
				@(negedge clk);
				k++;
			end
			check({12'h000, codeByte}, {12'h000, mem(base + 20'(i))});
			@(posedge clk) codeTake <= 1'b1;
			@(posedge clk) codeTake <= 1'b0;
		end
	endtask
	task automatic bus_req(input logic w, input logic [15:0] seg, input logic [15:0] off,
		input logic [15:0] wd);
		int k;
		k = 0;
		@(posedge clk) begin
			req <= '{seg: seg, off: off, wdata: wd, write: w, io: 1'b0, wordOp: 1'b1};
			reqValid <= 1'b1;
		end
		do @(negedge clk); while (reqReady !== 1'b1 && k++ < 300);
		@(posedge clk) reqValid <= 1'b0;
	endtask
	task automatic read_word(input logic [15:0] seg, input logic [15:0] off);
		logic [19:0] a;
		int k;
		a = {seg, 4'h0} + {4'h0, off};
		k = 0;
		bus_req(1'b0, seg, off, 16'h0000);
		while (rspValid !== 1'b1 && k < 300) begin
			@(negedge clk);
			k++;
		end
		check({4'h0, rspData}, {4'h0, mem(a + 20'h1), mem(a)});
	endtask
	task automatic write_word(input logic [15:0] seg, input logic [15:0] off,
		input logic [15:0] wd);
		int k;
		k = 0;
		bus_req(1'b1, seg, off, wd);
		while (lastWrAddr !== {seg, 4'h0} + {4'h0, off} && k < 300) begin
			@(negedge clk);
			k++;
		end
		repeat (8) @(negedge clk);
		check(lastWrAddr, {seg, 4'h0} + {4'h0, off});
		check({4'h0, lastWrData}, {4'h0, wd});
	endtask
	task automatic idle_when_full();
		repeat (80) @(posedge clk);
		latchCount = 0;
		repeat (40) @(posedge clk);
		check(20'(latchCount), 20'h0);
	endtask
	task automatic jump_to(input logic [15:0] seg, input logic [15:0] off);
		@(posedge clk) begin
			jumpValid <= 1'b1;
			jumpSeg <= seg;
			jumpOff <= off;
		end
		@(posedge clk) jumpValid <= 1'b0;
		pop_bytes({seg, 4'h0} + {4'h0, off}, 7);
	endtask

	initial begin
		#100us;
		num_errors++;
		wrap_up();
	end
	initial begin
		repeat (4) @(posedge clk);
		#1;
		check({19'h0, readStrobe_n}, 20'h1);
		check({4'h0, dataOe_n}, 20'h0FFFF);
		check({19'h0, codeValid}, 20'h0);
		@(posedge clk) rst <= 1'b0;
		idle_when_full();
		check({19'h0, smallMode}, 20'h1);
		pop_bytes(CPBI_RESET_CS, 10);
		waits <= 8'h03;
		read_word(16'hF800, 16'h7FF0);
		write_word(16'h1000, 16'h0024, 16'hA55A);
		waits <= 8'h00;
		read_word(16'h2000, 16'h0010);
		jump_to(16'h1234, 16'h0005);
		wrap_up();
	end
endmodule
